// ===== sse_cfg.svh
// register offsets, field positions and reset values of the spi slave engine
`ifndef SSE_CFG_SVH
`define SSE_CFG_SVH

// register byte offsets on the apb
`define SSE_OFF_CTRL      8'h00
`define SSE_OFF_TXHOLD    8'h04
`define SSE_OFF_RXHOLD    8'h08
`define SSE_OFF_OPTION    8'h0C

// control/status field positions
`define SSE_B_ENABLE      0
`define SSE_B_POLARITY    1
`define SSE_B_PHASE       2
`define SSE_B_RX_FULL     3
`define SSE_B_TX_EMPTY    4
`define SSE_B_DONE        5
`define SSE_B_OVERRUN     6
`define SSE_B_LSB_FIRST   7

// option register field positions
`define SSE_B_INVERT      0
`define SSE_B_SYNC_LO     1
`define SSE_B_FW_SRC      3
`define SSE_B_FW_LEVEL    4
`define SSE_B_IRQ_EN      5

// reset values: holding register empty, firmware select released
`define SSE_CTRL_RST      8'h10
`define SSE_OPTION_RST    8'h10
`define SSE_BYTE_RST      8'h00

// synchroniser depth and the stage tapped for each setting
`define SSE_SYNC_DEPTH    4
`define SSE_TAP_NONE      1
`define SSE_TAP_X2        2
`define SSE_TAP_SYS       3

`endif

// ===== sse_pkg.sv
// types shared by the spi slave engine files
package sse_pkg;

	// serial inputs that travel together
	typedef struct packed {
		logic sclk;
		logic mosi;
		logic ss_n;
	} sse_link_t;

	// control/status byte, bit 7 down to bit 0
	typedef struct packed {
		logic lsb_first;
		logic overrun;
		logic done;
		logic tx_empty;
		logic rx_full;
		logic phase;
		logic polarity;
		logic enable;
	} sse_ctrl_t;

	// input synchronisation choice
	typedef enum logic [1:0] {
		SSE_SYNC_SYS,
		SSE_SYNC_X2,
		SSE_SYNC_NONE
	} sse_sync_t;

	// option byte, bit 7 down to bit 0
	typedef struct packed {
		logic [1:0] reserved;
		logic       irq_en;
		logic       fw_level;
		logic       fw_src;
		logic [1:0] sync_sel;
		logic       invert;
	} sse_opt_t;

	// engine states
	typedef enum logic {
		SSE_IDLE,
		SSE_ACTIVE
	} sse_eng_t;

endpackage : sse_pkg

// ===== sse_sync.sv
// multi-stage input synchroniser with selectable taps
`timescale 1ns/1ps

module sse_sync #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic                        i_mclk,
	input  wire logic                        i_sys_rst,
	// asynchronous inputs
	input  wire logic [WIDTH-1:0]            i_async,
	// every stage after the first, stage 1 upward
	output logic      [DEPTH-1:1][WIDTH-1:0] o_taps
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] stage;
	} sse_sync_state_t;

	sse_sync_state_t st_ff;
	sse_sync_state_t nxt_st;

	// a single stage would hand a metastable value to logic
	if (DEPTH < 2)
	begin : g_chk
		$error("sse_sync needs at least two stages");
	end

	// stage 0 is read only by stage 1
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.stage[0] = i_async;
		for (int i = 1; i < DEPTH; i++)
		begin
			nxt_st.stage[i] = st_ff.stage[i-1];
		end
	end

	// chain registers, cleared by the synchronous reset
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign o_taps = st_ff.stage[DEPTH-1:1];

endmodule : sse_sync

// ===== sse_engine.sv
// 8-bit spi slave shift engine with apb register access
// Operation
// - optional inversion of master out input
// - three input synchronisation settings
// - only unsynchronised setting works in sleep
// - clock mode lives in bits 2:1
// - bit 7 selects low bit first
// - enable write applies mode and order
// - clearing enable stops the engine
// - interrupt enable gates done request
// - software byte goes to transmit holding
// - done at bit 5, overrun bit 6
// - tx empty bit 4, rx full bit 3
// - status read returns then clears done and overrun
// - receive holding read returns last byte
// - firmware deselect drives select high
// - firmware select drives select low
// - latch and change edges follow mode
// - select fall loads shift register
// - byte end fills rx, reloads, flags
// - unread byte plus new byte sets overrun
`include "sse_cfg.svh"
`timescale 1ns/1ps

module sse_engine #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic              i_mclk,
	input  wire logic              i_sys_rst,
	// apb slave
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	// serial link pins from the master
	input  wire logic              i_sclk,
	input  wire logic              i_mosi,
	input  wire logic              i_ss_n,
	output logic                   o_miso,
	// system sleep indication and done request
	input  wire logic              i_sleep,
	output logic                   o_irq
);

	// all engine state in one word, registered by a single process
	typedef struct packed {
		sse_pkg::sse_ctrl_t ctrl;
		sse_pkg::sse_opt_t  opt;
		logic [7:0]         tx_hold;
		logic [7:0]         rx_hold;
		logic [7:0]         shifter;
		logic [2:0]         bit_cnt;
		logic               miso;
		logic               sclk_prev;
		logic               ssn_prev;
		sse_pkg::sse_eng_t  eng;
		logic [7:0]         rdata;
	} sse_state_t;

	// reset: holding register shown empty, select seen released,
	// engine idle with enable clear, so a low select at start is not taken as a fall
	localparam sse_state_t STATE_RST = '{
		ctrl:      sse_pkg::sse_ctrl_t'(`SSE_CTRL_RST),
		opt:       sse_pkg::sse_opt_t'(`SSE_OPTION_RST),
		tx_hold:   `SSE_BYTE_RST,
		rx_hold:   `SSE_BYTE_RST,
		shifter:   `SSE_BYTE_RST,
		bit_cnt:   3'h0,
		miso:      1'b0,
		sclk_prev: 1'b0,
		ssn_prev:  1'b1,
		eng:       sse_pkg::SSE_IDLE,
		rdata:     `SSE_BYTE_RST
	};

	// the offsets must fit the address bus
	if (ADDR_W < 4)
	begin : g_chk
		$error("sse_engine needs ADDR_W of at least 4");
	end

	// more address bits than the bus carries make no sense
	if (ADDR_W > 32)
	begin : g_chk_wide
		$error("sse_engine needs ADDR_W of at most 32");
	end

	// every tap must exist; the shallowest still leaves two flops ahead of logic
	if (`SSE_TAP_NONE < 1 || `SSE_TAP_X2 < `SSE_TAP_NONE || `SSE_TAP_SYS < `SSE_TAP_X2
		|| `SSE_TAP_SYS > `SSE_SYNC_DEPTH - 1)
	begin : g_chk_taps
		$error("sse_engine taps do not fit the synchroniser");
	end

	sse_state_t st_ff;
	sse_state_t nxt_st;

	sse_pkg::sse_link_t                            link_raw;
	logic [`SSE_SYNC_DEPTH-1:1][$bits(sse_pkg::sse_link_t)-1:0] link_taps;

	// pins enter the clock domain through the synchroniser; the chain is as long
	// as the deepest tap, and shallower settings simply read an earlier stage
	// pins enter the clock domain through the synchroniser
	assign link_raw = '{sclk: i_sclk, mosi: i_mosi, ss_n: i_ss_n};

	sse_sync #(
		.WIDTH ($bits(sse_pkg::sse_link_t)),
		.DEPTH (`SSE_SYNC_DEPTH)
	) u_sync (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.i_async   (link_raw),
		.o_taps    (link_taps)
	);

	// combinational decode terms; all of them derive from registered state,
	// the synchronised taps, the sleep input or the apb inputs of this clock
	// combinational decode terms
	sse_pkg::sse_link_t link;
	sse_pkg::sse_sync_t sync_sel;
	logic               ssn_eff;
	logic               mosi_eff;
	logic               sclk_norm;
	logic               live;
	logic               lead_edge;
	logic               trail_edge;
	logic               sample_edge;
	logic               change_edge;
	logic               setup_ph;
	logic               access_ph;
	logic               hit_ctrl;
	logic               hit_tx;
	logic               hit_rx;
	logic               hit_opt;
	logic               addr_hit;
	logic               wr_tx;
	logic [7:0]         load_byte;
	logic [7:0]         shift_in;
	logic               out_bit;
	logic [ADDR_W-1:0]  addr;

	// input selection, edge finding and address decode
	always_comb
	begin
		sync_sel = sse_pkg::sse_sync_t'(st_ff.opt.sync_sel);
		// tap depth per setting; a code of 3 falls back to system clock
		unique case (sync_sel)
			sse_pkg::SSE_SYNC_NONE: link = sse_pkg::sse_link_t'(link_taps[`SSE_TAP_NONE]);
			sse_pkg::SSE_SYNC_X2:   link = sse_pkg::sse_link_t'(link_taps[`SSE_TAP_X2]);
			default:                link = sse_pkg::sse_link_t'(link_taps[`SSE_TAP_SYS]);
		endcase
		// firmware level replaces the select pin
		ssn_eff = st_ff.opt.fw_src ? st_ff.opt.fw_level : link.ss_n;
		mosi_eff = link.mosi ^ st_ff.opt.invert;
		// polarity folded so leading is always a rise
		sclk_norm = link.sclk ^ st_ff.ctrl.polarity;
		lead_edge = sclk_norm & ~st_ff.sclk_prev;
		trail_edge = ~sclk_norm & st_ff.sclk_prev;
		sample_edge = st_ff.ctrl.phase ? trail_edge : lead_edge;
		change_edge = st_ff.ctrl.phase ? lead_edge : trail_edge;
		// synchronised settings stand still in sleep
		live = st_ff.ctrl.enable & ~(i_sleep & (sync_sel != sse_pkg::SSE_SYNC_NONE));
		// apb phases
		setup_ph = i_psel & ~i_penable;
		access_ph = i_psel & i_penable;
		addr = i_paddr;
		hit_ctrl = addr == ADDR_W'(`SSE_OFF_CTRL);
		hit_tx = addr == ADDR_W'(`SSE_OFF_TXHOLD);
		hit_rx = addr == ADDR_W'(`SSE_OFF_RXHOLD);
		hit_opt = addr == ADDR_W'(`SSE_OFF_OPTION);
		addr_hit = hit_ctrl | hit_tx | hit_rx | hit_opt;
		wr_tx = access_ph & i_pwrite & hit_tx;
		// a byte written in the load cycle goes straight to the shifter
		load_byte = wr_tx ? i_pwdata[7:0] : st_ff.tx_hold;
		shift_in = st_ff.ctrl.lsb_first ? {mosi_eff, st_ff.shifter[7:1]}
		                                : {st_ff.shifter[6:0], mosi_eff};
		// bit presented on a change edge, msb or lsb per order
		out_bit = st_ff.ctrl.lsb_first ? st_ff.shifter[0] : st_ff.shifter[7];
	end

	// next state: bus effects first so engine flag sets win
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.sclk_prev = sclk_norm;
		nxt_st.ssn_prev = ssn_eff;

		// a control read remembers what it returned, so the access edge
		// clears only those flags and never one set in between
		// read data is captured in the setup cycle
		if (setup_ph & ~i_pwrite)
		begin
			if (hit_ctrl)
				nxt_st.rdata = st_ff.ctrl;
			else if (hit_tx)
				nxt_st.rdata = st_ff.tx_hold;
			else if (hit_rx)
				nxt_st.rdata = st_ff.rx_hold;
			else if (hit_opt)
				nxt_st.rdata = st_ff.opt;
			else
				nxt_st.rdata = 8'h00;
		end

		// register writes at the access edge
		if (access_ph & i_pwrite)
		begin
			// mode, order and enable; flags stay read-only
			// mode bits 2:1, order bit 7
			if (hit_ctrl)
			begin
				nxt_st.ctrl.enable = i_pwdata[`SSE_B_ENABLE];
				nxt_st.ctrl.polarity = i_pwdata[`SSE_B_POLARITY];
				nxt_st.ctrl.phase = i_pwdata[`SSE_B_PHASE];
				nxt_st.ctrl.lsb_first = i_pwdata[`SSE_B_LSB_FIRST];
			end
			// byte for the master into holding
			if (hit_tx)
			begin
				nxt_st.tx_hold = i_pwdata[7:0];
				nxt_st.ctrl.tx_empty = 1'b0;
			end
			// option byte, reserved bits read zero
			if (hit_opt)
			begin
				nxt_st.opt = sse_pkg::sse_opt_t'(i_pwdata[7:0]);
				nxt_st.opt.reserved = 2'b00;
			end
		end

		// read side effects at the access edge
		if (access_ph & ~i_pwrite)
		begin
			// clear only flags that were returned
			if (hit_ctrl)
			begin
				nxt_st.ctrl.done = st_ff.ctrl.done & ~st_ff.rdata[`SSE_B_DONE];
				nxt_st.ctrl.overrun = st_ff.ctrl.overrun & ~st_ff.rdata[`SSE_B_OVERRUN];
			end
			// taking the byte empties the buffer
			if (hit_rx)
				nxt_st.ctrl.rx_full = 1'b0;
		end

		// serial engine
		// a disable, a sleep stop or a select rise drops a part byte without
		// flags: the master sees a short byte, software never a torn one
		// latch and change never meet in one edge, one is a rise of the
		// folded clock and the other a fall
		unique case (st_ff.eng)
			sse_pkg::SSE_IDLE:
			begin
				// a low select at enable is ignored until it rises
				// select fall loads shifter, first bit out
				if (live & st_ff.ssn_prev & ~ssn_eff)
				begin
					nxt_st.shifter = load_byte;
					nxt_st.ctrl.tx_empty = 1'b1;
					nxt_st.miso = st_ff.ctrl.lsb_first ? load_byte[0] : load_byte[7];
					nxt_st.bit_cnt = 3'h0;
					nxt_st.eng = sse_pkg::SSE_ACTIVE;
				end
			end
			sse_pkg::SSE_ACTIVE:
			begin
				// disable or deselect abandons the byte
				if (~live | ssn_eff)
				begin
					nxt_st.bit_cnt = 3'h0;
					nxt_st.eng = sse_pkg::SSE_IDLE;
				end
				// latch edge takes one bit in
				else if (sample_edge)
				begin
					nxt_st.shifter = shift_in;
					nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
					if (st_ff.bit_cnt == 3'h7)
					begin
						nxt_st.rx_hold = shift_in;
						nxt_st.shifter = load_byte;
						nxt_st.ctrl.tx_empty = 1'b1;
						nxt_st.ctrl.rx_full = 1'b1;
						nxt_st.ctrl.done = 1'b1;
						if (st_ff.ctrl.rx_full)
							nxt_st.ctrl.overrun = 1'b1;
					end
				end
				// change edge presents the next bit
				else if (change_edge)
				begin
					nxt_st.miso = out_bit;
				end
			end
		endcase
	end

	// single state register, synchronous reset; the synchroniser is cleared by the
	// same reset, so its taps read zero until pin levels have passed through
	// single state register, synchronous reset
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
			st_ff <= STATE_RST;
		else
			st_ff <= nxt_st;
	end

	// pready is tied high: every register answers in its access cycle,
	// so a master never waits on this slave
	// outputs: zero wait states, unmapped access flags an error
	assign o_prdata = {24'h00_0000, st_ff.rdata};
	assign o_pready = 1'b1;
	assign o_pslverr = access_ph & ~addr_hit;
	assign o_miso = st_ff.miso;

	// done request gated by interrupt enable
	assign o_irq = st_ff.ctrl.done & st_ff.opt.irq_en;

endmodule : sse_engine

// ===== sse_engine_properties.sv
// port assertions for the spi slave engine
`timescale 1ns/1ps
module sse_engine_properties #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic              i_mclk,
	input wire logic              i_sys_rst,
	// apb
	input wire logic              i_psel,
	input wire logic              i_penable,
	input wire logic              i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0]       i_pwdata,
	input wire logic [31:0]       o_prdata,
	input wire logic              o_pslverr,
	// link and request
	input wire logic              i_ss_n,
	input wire logic              o_miso,
	input wire logic              o_irq
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);

	// decoded bus phases
	wire acc = i_psel && i_penable;
	wire su_rd = i_psel && !i_penable && !i_pwrite;
	wire bad = !(i_paddr inside {0, 4, 8, 12});
	wire st_rd = acc && !i_pwrite && i_paddr == 0;

	reset_quiet_a: assert property (disable iff (1'b0) i_sys_rst |=> !o_irq && !o_miso)
		else $error("irq or miso set after reset");
	irq_clear_a: assert property (st_rd |=> !o_irq)
		else $error("irq kept after status read");
	mode_back_a: assert property (acc && i_pwrite && i_paddr == 0 ##2 su_rd && i_paddr == 0
		|=> (o_prdata & 32'h0000_0087) == ($past(i_pwdata, 3) & 32'h0000_0087))
		else $error("mode bits not read back");
	tx_back_a: assert property (acc && i_pwrite && i_paddr == 4 ##2 su_rd && i_paddr == 4
		|=> o_prdata == ($past(i_pwdata, 3) & 32'h0000_00FF))
		else $error("tx holding not read back");
	// a deselected link leaves miso alone
	miso_quiet_a: assert property ((i_ss_n && !i_psel) [*8] |=> $stable(o_miso))
		else $error("miso moved while deselected");
	err_map_a: assert property (acc && bad |-> o_pslverr)
		else $error("unmapped access without error");
	err_only_a: assert property (o_pslverr |-> acc && bad)
		else $error("error on a mapped access");
	bad_zero_a: assert property (su_rd && bad |=> o_prdata == 32'h0)
		else $error("unmapped read not zero");

	// main scenarios reached
	cover property (o_irq);
	cover property (st_rd && o_prdata[6]);
	cover property ($fell(i_ss_n));
endmodule : sse_engine_properties

bind sse_engine sse_engine_properties #(.ADDR_W(ADDR_W)) chk (.*);

// ===== sse_spi_master.sv
// spi master model driving the engine's link pins
`timescale 1ns/1ps
module sse_spi_master (
	// link pins
	output logic      o_sclk,
	output logic      o_mosi,
	output logic      o_ss_n,
	input  wire logic i_miso
);
	// half of the 48 ns link period
	localparam realtime HALF = 24.0;

	initial
	begin
		o_sclk = 1'b0;
		o_mosi = 1'b0;
		o_ss_n = 1'b1;
	end

	// one byte; m is {lsb first, phase, polarity}
	task automatic xfer(input logic [2:0] m, input logic [7:0] tx, output logic [7:0] rx);
		int k;
		o_sclk = m[0];
		#HALF o_ss_n = 1'b0;
		#(2 * HALF);
		for (int i = 0; i < 8; i++)
		begin
			k = m[2] ? i : 7 - i;
			if (!m[1])
				o_mosi = tx[k];
			#HALF o_sclk = ~o_sclk;
			if (m[1])
				o_mosi = tx[k];
			else
				rx[k] = i_miso;
			#HALF o_sclk = ~o_sclk;
			if (m[1])
				rx[k] = i_miso;
		end
		// clock stands still; mosi shows no stale level
		#HALF o_ss_n = 1'b1;
		o_mosi = ~o_mosi;
	endtask : xfer
endmodule : sse_spi_master

// ===== sse_tb.sv
// self-checking bench for the spi slave engine
`include "sse_cfg.svh"
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %0t %h %h", $time, g, e); end end

module testbench;
	// config, option, tx, mosi byte; expected miso, rx, status
	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] opt;
		logic [7:0] tx;
		logic [7:0] mo;
		logic [7:0] so;
		logic [7:0] rx;
		logic [7:0] st;
	} sse_row_t;
	localparam sse_row_t ROWS [7] = '{56'h0104_A53C_A53C_39, 56'h0304_5AC3_5AC3_3B,
		56'h8504_9681_9681_BD, 56'h8704_697E_697E_BF, 56'h0105_F00F_F0F0_39,
		56'h0102_0012_0012_39, 56'h0100_0024_0024_39};
	localparam logic [7:0] CT = `SSE_OFF_CTRL;
	localparam logic [7:0] TX = `SSE_OFF_TXHOLD;
	localparam logic [7:0] RX = `SSE_OFF_RXHOLD;
	localparam logic [7:0] OP = `SSE_OFF_OPTION;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sleep = 0;
	logic [7:0] paddr = 0, q, so;
	logic [31:0] pwdata = 0, prdata;
	logic pready, perr, sclk, mosi, ss_n, miso, irq, e;
	int checked = 0, bad_count = 0, cyc = 0;
	sse_row_t r;

	sse_engine dut (.i_mclk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
		.i_sclk(sclk), .i_mosi(mosi), .i_ss_n(ss_n), .o_miso(miso), .i_sleep(sleep), .o_irq(irq));
	sse_spi_master mst (.o_sclk(sclk), .o_mosi(mosi), .o_ss_n(ss_n), .i_miso(miso));

	// 200 MHz clock
	initial
		forever #2.5 clk = ~clk;

	// one apb transfer, waiting on pready
	task automatic bus(input logic w, input logic [7:0] a, d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata[7:0];
		e = perr;
		psel <= 0;
		pen <= 0;
	endtask : bus

	task automatic rd(input logic [7:0] a, x);
		bus(1'b0, a, 8'h00);
		`CHK(q, x)
	endtask : rd

	// covers the synchroniser latency
	task settle;
		repeat (12) @(posedge clk);
	endtask : settle

	task complete_run;
		$display("checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	// hang guard, far above the ~1400 cycles needed
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			complete_run();
		end
	end

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 0;
		// ordinary frames; asleep only when unsynchronised
		foreach (ROWS[j])
		begin
			r = ROWS[j];
			sleep <= r.opt[2];
			bus(1, OP, r.opt);
			bus(1, TX, r.tx);
			bus(1, CT, r.cfg);
			mst.xfer({r.cfg[7], r.cfg[2:1]}, r.mo, so);
			settle();
			`CHK(so, r.so)
			rd(CT, r.st);
			rd(RX, r.rx);
			$display("row %0d end", j);
		end
		// masked, unmasked, then overrun
		bus(1, OP, 8'h04);
		mst.xfer(3'h0, 8'h11, so);
		settle();
		`CHK(irq, 1'b0)
		bus(1, OP, 8'h24);
		settle();
		`CHK(irq, 1'b1)
		mst.xfer(3'h0, 8'h22, so);
		settle();
		rd(CT, 8'h79);
		@(posedge clk);
		`CHK(irq, 1'b0)
		rd(RX, 8'h22);
		$display("overrun end");
		// disabled engine ignores a frame
		bus(1, CT, 8'h00);
		mst.xfer(3'h0, 8'h33, so);
		settle();
		rd(CT, 8'h10);
		rd(RX, 8'h22);
		// asleep with synchronised inputs
		sleep <= 1;
		bus(1, OP, 8'h00);
		bus(1, CT, 8'h01);
		mst.xfer(3'h0, 8'h44, so);
		settle();
		rd(CT, 8'h11);
		sleep <= 0;
		$display("idle end");
		// firmware select loads on each fall
		bus(1, OP, 8'h18);
		bus(1, TX, 8'h77);
		rd(TX, 8'h77);
		bus(1, OP, 8'h08);
		settle();
		rd(CT, 8'h11);
		bus(1, OP, 8'h18);
		bus(1, TX, 8'h55);
		bus(1, OP, 8'h08);
		settle();
		rd(CT, 8'h11);
		$display("select end");
		// second reset, reset values, unmapped place
		rst <= 1;
		repeat (4) @(posedge clk);
		rst <= 0;
		rd(CT, 8'h10);
		rd(OP, 8'h10);
		rd(RX, 8'h00);
		rd(8'h10, 8'h00);
		`CHK(e, 1'b1)
		bus(1, CT, 8'h87);
		rd(CT, 8'h97);
		$display("reset end");
		complete_run();
	end
endmodule : testbench
